// [tb/apmss_assertions.sv]
// Concurrent checks on the ports of the mute source select block.
`timescale 1ns/1ns
`default_nettype none
module apmss_checker (
  input wire clk_sys, srst, psel, penable, pwrite, mute_in_port2,
  input wire [31:0] paddr, pwdata, prdata,
  input wire [1:0] tx_clock_class, rx_clock_class
);
  wire wr = psel && penable && pwrite;
  wire ws = wr && paddr == 32'h40000020;
  wire wc = wr && paddr == 32'h40000028;
  wire rs = psel && penable && !pwrite && paddr == 32'h40000020;
  default clocking @(posedge clk_sys); endclocking
  default disable iff (srst);
  a_mute_reset: assert property ($fell(srst) |-> !mute_in_port2) else $error("mute");
  a_class_reset: assert property ($fell(srst) |-> tx_clock_class == 2'h1) else $error("class");
  a_sel_zero: assert property (ws && pwdata[2:0] == 3'h0 |=> !mute_in_port2 [*3]) else $error("zero");
  a_rsvd_zero: assert property (rs |-> prdata[31:3] == 29'h0) else $error("reserved");
  a_tx_cause: assert property ($changed(tx_clock_class) |-> $past(wr)) else $error("tx");
  a_rx_cause: assert property ($changed(rx_clock_class) |-> $past(wr)) else $error("rx");
  a_tx_internal: assert property (wc && pwdata[1:0] == 2'h3 |=> tx_clock_class == 2'h0) else $error("txi");
  a_rx_internal: assert property (wc && pwdata[3:2] == 2'h3 |=> rx_clock_class == 2'h0) else $error("rxi");
endmodule // apmss_checker
bind apmss_top apmss_checker apmss_checker_inst (.*);
`default_nettype wire

// [tb/test_apmss_top.sv]
// Self-checking bench of the mute source select block.
`timescale 1ns/1ns
`default_nettype none
module test_apmss_top;
  logic clk_sys = 1'b0, srst = 1'b1, psel = 1'b0, penable = 1'b0, pwrite = 1'b0, err;
  logic [31:0] paddr = 32'h0, pwdata = 32'h0, rd;
  logic [6:0] src = 7'h0;
  wire pready, pslverr, mute_in_port2, rx_hifreq_clock_port2, spi0_simo, spi0_cs, spi0_ena;
  wire [31:0] prdata;
  wire [2:0] serial_data_pins_port0;
  wire [1:0] tx_clock_class, rx_clock_class;
  wire [31:0] prdata_lite;
  wire mute_lite;
  int fails = 0, check_count = 0;
  assign {spi0_ena, spi0_cs, spi0_simo, rx_hifreq_clock_port2, serial_data_pins_port0} = src;
  apmss_top apmss_top_inst (.*);
  // Variant without port 2 shares bus and pins, so every write reaches it as well.
  apmss_top #(.PORT2_PRESENT(0)) apmss_top_lite_inst (.clk_sys(clk_sys), .srst(srst), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(), .pslverr(),
    .prdata(prdata_lite), .serial_data_pins_port0(serial_data_pins_port0),
    .rx_hifreq_clock_port2(rx_hifreq_clock_port2), .spi0_simo(spi0_simo), .spi0_cs(spi0_cs),
    .spi0_ena(spi0_ena), .mute_in_port2(mute_lite), .tx_clock_class(), .rx_clock_class());
  initial forever #20 clk_sys = ~clk_sys;
  task chk(input string n, input logic [31:0] e, input logic [31:0] g);
    check_count++;
    if (g !== e) begin
      fails++;
      $display("BAD %s exp %h got %h", n, e, g);
    end
  endtask
  task apb(input logic w, input logic [31:0] a, input logic [31:0] d);
    {psel, pwrite, paddr, pwdata} <= {1'b1, w, a, d};
    @(posedge clk_sys) penable <= 1'b1;
    do @(posedge clk_sys); while (pready !== 1'b1);
    {rd, err} = {prdata, pslverr};
    {psel, penable} <= 2'h0;
    @(posedge clk_sys);
  endtask
  task test_reset;
    apb(1'b0, 32'h40000020, 0);
    chk("reset", 0, rd);
    src <= 7'h7f;
    apb(1'b1, 32'h40000020, 32'h5);
    apb(1'b1, 32'h40000028, 32'hf);
    chk("mute before reset", 1, mute_in_port2);
    srst <= 1'b1;
    repeat (2) @(posedge clk_sys);
    srst <= 1'b0;
    apb(1'b0, 32'h40000020, 0);
    chk("reset again", 0, rd);
    chk("tx after reset", 1, tx_clock_class);
    chk("rx after reset", 1, rx_clock_class);
    chk("mute after reset", 0, mute_in_port2);
    $display("reset test done");
  endtask
  task test_mute;
    for (int c = 0; c < 8; c++) begin
      apb(1'b1, 32'h40000020, c);
      // Only the chosen pin is high, so a wrong choice reads low; code zero sees all pins high.
      src <= c ? 7'(8'h1 << c >> 1) : 7'h7f;
      @(posedge clk_sys) chk("mute", c != 0, mute_in_port2);
      chk("lite mute", 0, mute_lite);
      apb(1'b0, 32'h40000020, 0);
      chk("selector", c, rd);
      chk("lite selector", 0, prdata_lite);
    end
    $display("mute test done");
  endtask
  task test_clk;
    logic [3:0] m;
    for (int i = 0; i < 16; i++) begin
      m = 4'(i);
      apb(1'b1, 32'h40000028, {28'h0, m});
      chk("tx class", {m[0] ^ m[1], ~m[1]}, tx_clock_class);
      chk("rx class", {m[2] ^ m[3], ~m[3]}, rx_clock_class);
      apb(1'b0, 32'h40000024, 0);
      chk("class word", {28'h0, m[2] ^ m[3], ~m[3], m[0] ^ m[1], ~m[1]}, rd);
      apb(1'b0, 32'h40000028, 0);
      chk("control", {28'h0, m}, rd);
    end
    apb(1'b0, 32'h40000030, 0);
    chk("unmapped", 1, err);
    chk("unmapped data", 0, rd);
    $display("clock test done");
  endtask
  task final_report;
    $display("checks %0d mismatches %0d", check_count, fails);
    if (fails == 0 && check_count > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  initial begin
    repeat (4) @(posedge clk_sys);
    srst <= 1'b0;
    test_reset;
    test_mute;
    test_clk;
    final_report;
  end
  initial begin
    #40000;
    fails++;
    final_report;
  end
endmodule // test_apmss_top
`default_nettype wire

// [verilog/apmss_clk_class.v]
// Classifier of one bit clock from its clock-mode bit and its pin direction.
`timescale 1ns/1ns
`default_nettype none
`include "apmss_regs.vh"
module apmss_clk_class (
  input wire clk_mode,
  input wire pin_dir,
  output reg [1:0] cls
);
  // Mode set with an input pin is not a documented class and is flagged apart.
  always @* begin
    case ({clk_mode, pin_dir})
      2'h3: cls = `APMSS_CLS_INTERNAL;
      2'h0: cls = `APMSS_CLS_EXT_IN;
      2'h1: cls = `APMSS_CLS_EXT_OUT;
      default: cls = `APMSS_CLS_INVALID;
    endcase
  end
endmodule // apmss_clk_class
`default_nettype wire

// [verilog/apmss_regs.vh]
// Register map, field positions and codes of the audio port mute source select block.
`ifndef APMSS_REGS_VH
`define APMSS_REGS_VH
`define APMSS_SEL_ADDR 32'h40000020
`define APMSS_CLKCLS_ADDR 32'h40000024
`define APMSS_CLKCTL_ADDR 32'h40000028
`define APMSS_SEL_LSB 0
`define APMSS_SEL_MSB 2
`define APMSS_SEL_RESET 3'h0
`define APMSS_CODE_ZERO 3'h0
`define APMSS_CODE_SD7 3'h1
`define APMSS_CODE_SD8 3'h2
`define APMSS_CODE_SD9 3'h3
`define APMSS_CODE_HFCLK 3'h4
`define APMSS_CODE_SPI0_SIMO 3'h5
`define APMSS_CODE_SPI0_CS 3'h6
`define APMSS_CODE_SPI0_ENA 3'h7
`define APMSS_CLS_INTERNAL 2'h0
`define APMSS_CLS_EXT_IN 2'h1
`define APMSS_CLS_EXT_OUT 2'h2
`define APMSS_CLS_INVALID 2'h3
`define APMSS_CTL_TX_MODE 0
`define APMSS_CTL_TX_DIR 1
`define APMSS_CTL_RX_MODE 2
`define APMSS_CTL_RX_DIR 3
`define APMSS_CTL_LSB 0
`define APMSS_CTL_MSB 3
`define APMSS_CTL_RESET 4'h0
`define APMSS_RDATA_RESET 32'h00000000
`endif

// [verilog/apmss_top.v]
// APB register slave, mute source multiplexer and bit clock classes for audio port 2.
//
// How it works
// RQ1 - Three-bit read/write selector in low register bits, reset to zero.
// RQ2 - Upper bits reserved; they read as zero, writes to them are dropped.
// RQ3 - Code 000 drives the mute input with constant zero.
// RQ4 - Codes 001-011 route port 0 serial data pins 7, 8, 9.
// RQ5 - Code 100 routes port 2 receive high-frequency clock pin.
// RQ6 - Codes 101-111 route SPI0 slave-in, chip-select, enable pins.
// RQ7 - Without port 2 present, the selector reads zero and has no effect.
// RQ8 - Transmit bit clock classed from mode bit and pin direction.
// RQ9 - Receive bit clock classed from mode bit and pin direction.
// RQ10 - Mute input follows the selector combinationally, no enable needed.
//
// Local design decision: the APB interface to the registers.
`timescale 1ns/1ns
`default_nettype none
`include "apmss_regs.vh"
module apmss_top #(
  parameter PORT2_PRESENT = 1
) (
  input wire clk_sys,
  input wire srst,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [31:0] paddr,
  input wire [31:0] pwdata,
  output wire pready,
  output wire pslverr,
  output reg [31:0] prdata,
  input wire [2:0] serial_data_pins_port0,
  input wire rx_hifreq_clock_port2,
  input wire spi0_simo,
  input wire spi0_cs,
  input wire spi0_ena,
  output reg mute_in_port2,
  output wire [1:0] tx_clock_class,
  output wire [1:0] rx_clock_class
);
  // Register state and its next values.
  reg [2:0] mute_source_sel_r;
  reg [2:0] mute_source_sel_nxt;
  reg [3:0] clk_ctl_r;
  reg [3:0] clk_ctl_nxt;
  reg [1:0] tx_class_r;
  reg [1:0] rx_class_r;
  reg [31:0] rdata_nxt;
  reg [2:0] sel_eff;

  // Bus phase and address decode.
  wire setup_phase;
  wire access_phase;
  wire rd_setup;
  wire wr_access;
  wire hit_sel;
  wire hit_cls;
  wire hit_ctl;
  wire hit_any;
  wire wr_sel;
  wire wr_ctl;
  wire port2_on;
  wire [1:0] tx_class_nxt;
  wire [1:0] rx_class_nxt;

  assign setup_phase = psel & ~penable;
  assign access_phase = psel & penable;
  assign rd_setup = setup_phase & ~pwrite;
  assign wr_access = access_phase & pwrite;

  assign hit_sel = (paddr == `APMSS_SEL_ADDR);
  assign hit_cls = (paddr == `APMSS_CLKCLS_ADDR);
  assign hit_ctl = (paddr == `APMSS_CLKCTL_ADDR);
  assign hit_any = hit_sel | hit_cls | hit_ctl;

  // The class status register is read only, so only two registers take writes.
  assign wr_sel = wr_access & hit_sel;
  assign wr_ctl = wr_access & hit_ctl;

  // Zero wait states; an unmapped address answers with an error and changes nothing.
  assign pready = 1'b1;
  assign pslverr = access_phase & ~hit_any;

  // A variant without port 2 keeps the selector at its reset value.
  assign port2_on = (PORT2_PRESENT != 0);

  // Bits above the selector are reserved and never stored.
  always @* begin
    mute_source_sel_nxt = mute_source_sel_r;
    if (wr_sel && port2_on) begin
      mute_source_sel_nxt = pwdata[`APMSS_SEL_MSB:`APMSS_SEL_LSB]; // [RQ1] [RQ2] [RQ7]
    end
  end

  always @* begin
    clk_ctl_nxt = clk_ctl_r;
    if (wr_ctl) begin
      clk_ctl_nxt = pwdata[`APMSS_CTL_MSB:`APMSS_CTL_LSB];
    end
  end

  // Read data is taken in the setup phase so it stands through the whole access phase.
  always @* begin
    rdata_nxt = prdata;
    if (rd_setup) begin
      if (hit_sel) begin
        rdata_nxt = {29'h0, mute_source_sel_r}; // [RQ2] [RQ7]
      end else if (hit_cls) begin
        rdata_nxt = {28'h0, rx_class_r, tx_class_r};
      end else if (hit_ctl) begin
        rdata_nxt = {28'h0, clk_ctl_r};
      end else begin
        rdata_nxt = `APMSS_RDATA_RESET;
      end
    end
  end

  // Classes are registered from the next control value, so they move together with it.
  // Control resets to mode 0 with an input pin, which is the external input class.
  always @(posedge clk_sys) begin
    if (srst) begin
      mute_source_sel_r <= `APMSS_SEL_RESET; // [RQ1]
      clk_ctl_r <= `APMSS_CTL_RESET;
      tx_class_r <= `APMSS_CLS_EXT_IN;
      rx_class_r <= `APMSS_CLS_EXT_IN;
      prdata <= `APMSS_RDATA_RESET;
    end else begin
      mute_source_sel_r <= mute_source_sel_nxt;
      clk_ctl_r <= clk_ctl_nxt;
      tx_class_r <= tx_class_nxt; // [RQ8]
      rx_class_r <= rx_class_nxt; // [RQ9]
      prdata <= rdata_nxt;
    end
  end

  assign tx_clock_class = tx_class_r;
  assign rx_clock_class = rx_class_r;

  always @* begin
    sel_eff = port2_on ? mute_source_sel_r : `APMSS_CODE_ZERO; // [RQ7]
  end

  // Pure mux: a selector change reaches the mute input at once, so glitches are possible.
  always @* begin
    case (sel_eff) // [RQ10]
      `APMSS_CODE_ZERO: mute_in_port2 = 1'b0; // [RQ3]
      `APMSS_CODE_SD7: mute_in_port2 = serial_data_pins_port0[0]; // [RQ4]
      `APMSS_CODE_SD8: mute_in_port2 = serial_data_pins_port0[1]; // [RQ4]
      `APMSS_CODE_SD9: mute_in_port2 = serial_data_pins_port0[2]; // [RQ4]
      `APMSS_CODE_HFCLK: mute_in_port2 = rx_hifreq_clock_port2; // [RQ5]
      `APMSS_CODE_SPI0_SIMO: mute_in_port2 = spi0_simo; // [RQ6]
      `APMSS_CODE_SPI0_CS: mute_in_port2 = spi0_cs; // [RQ6]
      `APMSS_CODE_SPI0_ENA: mute_in_port2 = spi0_ena; // [RQ6]
      default: mute_in_port2 = 1'b0;
    endcase
  end

  apmss_clk_class apmss_clk_class_inst ( // [RQ8]
    .clk_mode(clk_ctl_nxt[`APMSS_CTL_TX_MODE]),
    .pin_dir(clk_ctl_nxt[`APMSS_CTL_TX_DIR]),
    .cls(tx_class_nxt)
  );

  apmss_clk_class apmss_clk_class_rx_inst ( // [RQ9]
    .clk_mode(clk_ctl_nxt[`APMSS_CTL_RX_MODE]),
    .pin_dir(clk_ctl_nxt[`APMSS_CTL_RX_DIR]),
    .cls(rx_class_nxt)
  );
endmodule // apmss_top
`default_nettype wire
